// ---- clpc_top.sv ----
// Clock source, prescaler, trim and low-power mode controller
// Contract
// - Reset selects internal 8 MHz RC clock
// - External 4-32 MHz clock selectable and monitored
// - External failure falls back to RC automatically
// - Failure interrupt only when its enable set
// - Phase-locked loop input faults raise interrupt
// - Prescalers make bus clocks, max 48 MHz; faster settings are only flagged
// - 48 MHz RC drives system or PLL
// - Trimmer retunes 48 MHz RC from sync
// - Sleep halts processor clock only; events wake
// - Stop gates core clocks, disables three oscillators
// - Stop keeps memory and registers intact
// - Any event line wakes from Stop
// - Serial peripherals may request RC in Stop
// - Stop leaves calendar and watchdog clocks running
// - Low secondary supply disables its I/Os
// - Secondary supply comparator drives event line 31
`timescale 1ns/1ns
module clpc_top
  import clpc_pkg::*;
#(
  parameter int EXT_MHZ = 8,
  parameter int PLL_MUL = 4,
  parameter logic [15:0] SYNC_TARGET = 16'd1500,
  parameter logic [15:0] TRIM_TOL = 16'd3
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire clpc_src_t sw_sysclk_sel,
  input wire logic ext_osc_on,
  input wire logic rc48_on,
  input wire logic pll_on,
  input wire logic [1:0] pll_src_sel,
  input wire logic css_irq_en,
  input wire logic pll_irq_en,
  input wire logic css_flag_clr,
  input wire logic pll_flag_clr,
  input wire logic [3:0] ahb_shift,
  input wire logic [2:0] apb_shift,
  input wire logic trim_auto_en,
  input wire logic [5:0] trim_sw,
  input wire logic sleep_req,
  input wire logic stop_req,
  input wire logic irq_pending,
  input wire logic [31:0] event_wake_mask,
  input wire logic [3:0] rc8_wake_req,
  input wire logic ext_clk_tick,
  input wire logic ext_ready,
  input wire logic rc48_ready,
  input wire logic pll_lock,
  input wire logic sync_in,
  input wire logic rc48_tick,
  input wire logic io2_below_ref,
  input wire logic [30:0] event_lines,
  output logic [3:0] sysclk_gate,
  output clpc_src_t sysclk_src,
  output logic switch_busy,
  output logic css_flag_ff,
  output logic pll_flag_ff,
  output logic clk_irq_ff,
  output logic ahb_tick_ff,
  output logic apb_tick_ff,
  output logic bus_overspeed_ff,
  output logic [5:0] rc48_trim_ff,
  output logic cpu_clk_en_ff,
  output logic core_clk_en_ff,
  output logic rc8_en_ff,
  output logic ext_osc_en_ff,
  output logic pll_en_ff,
  output logic rc48_en_ff,
  output logic lowspeed_keep_en_ff,
  output logic retain_en_ff,
  output logic io2_disable_ff,
  output logic event_line31_ff,
  output clpc_pwr_t power_state_ff,
  output logic wake_pulse_ff
);

  // Frequency of a source in MHz
  function automatic int src_mhz(input clpc_src_t s, input logic [1:0] psel);
    int pin;
    pin = (psel == PLLSRC_EXT) ? EXT_MHZ : (psel == PLLSRC_RC48) ? RC48_MHZ : RC8_MHZ;
    unique case (s)
      SRC_RC8:  src_mhz = RC8_MHZ;
      SRC_EXT:  src_mhz = EXT_MHZ;
      SRC_RC48: src_mhz = RC48_MHZ;
      SRC_PLL:  src_mhz = pin * PLL_MUL;
    endcase
  endfunction

  // Divider terminal count for a power-of-two shift
  function automatic logic [8:0] div_limit(input logic [3:0] sh);
    logic [3:0] s;
    s = (sh > AHB_SHIFT_MAX) ? AHB_SHIFT_MAX : sh;
    div_limit = 9'((32'd1 << s) - 32'd1);
  endfunction

  logic [PIN_W-1:0] pin_a_ff;
  logic [PIN_W-1:0] pin_b_ff;
  logic ext_tick_prev_ff;
  logic rc48_tick_prev_ff;
  logic sync_prev_ff;
  logic [7:0] fail_cnt_ff;
  logic ext_failed_ff;
  logic force_rc8_ff;
  logic pll_was_locked_ff;
  logic [8:0] ahb_cnt_ff;
  logic [8:0] apb_cnt_ff;
  logic [15:0] trim_cnt_ff;
  clpc_pwr_t nxt_power_state;
  clpc_src_t req_src;
  logic [31:0] evt_all;
  logic any_wake_evt;
  logic ext_in_use;
  logic ext_edge;
  logic css_evt;
  logic pll_evt;
  logic [3:0] src_ready;
  logic [8:0] ahb_lim;
  logic [8:0] apb_lim;
  logic sync_rise;
  logic rc48_edge;
  int sys_mhz;

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_a_ff <= '0;
      pin_b_ff <= '0;
    end else begin
      pin_a_ff <= {event_lines, io2_below_ref, rc48_tick, sync_in, pll_lock, rc48_ready,
                   ext_ready, ext_clk_tick};
      pin_b_ff <= pin_a_ff;
    end
  end

  // Event lines: 0..30 from pins, 31 from the secondary supply comparator
  assign evt_all = {pin_b_ff[PIN_EVT_LSB], pin_b_ff[PIN_W-1:PIN_EVT_LSB+1]};
  assign any_wake_evt = |(evt_all & event_wake_mask);

  // Secondary supply monitor outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io2_disable_ff <= 1'b0;
      event_line31_ff <= 1'b0;
    end else begin
      io2_disable_ff <= pin_b_ff[PIN_EVT_LSB];
      event_line31_ff <= pin_b_ff[PIN_EVT_LSB];
    end
  end

  // Power mode next state
  always_comb begin
    nxt_power_state = power_state_ff;
    unique case (power_state_ff)
      PWR_RUN: begin
        if (stop_req) begin
          nxt_power_state = PWR_STOP;
        end else if (sleep_req) begin
          nxt_power_state = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (irq_pending || any_wake_evt) begin
          nxt_power_state = PWR_RUN;
        end
      end
      PWR_STOP: begin
        if (any_wake_evt) begin
          nxt_power_state = PWR_RUN;
        end
      end
      default: nxt_power_state = PWR_RUN;
    endcase
  end

  // Power mode state and wake pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_state_ff <= PWR_RUN;
      wake_pulse_ff <= 1'b0;
    end else begin
      power_state_ff <= nxt_power_state;
      wake_pulse_ff <= (power_state_ff != PWR_RUN) && (nxt_power_state == PWR_RUN);
    end
  end

  // Clock and oscillator enables per power mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en_ff <= 1'b1;
      core_clk_en_ff <= 1'b1;
      retain_en_ff <= 1'b0;
      rc8_en_ff <= 1'b1;
      ext_osc_en_ff <= 1'b0;
      pll_en_ff <= 1'b0;
      rc48_en_ff <= 1'b0;
      lowspeed_keep_en_ff <= 1'b0;
    end else begin
      cpu_clk_en_ff <= nxt_power_state == PWR_RUN;
      core_clk_en_ff <= nxt_power_state != PWR_STOP;
      retain_en_ff <= nxt_power_state == PWR_STOP;
      rc8_en_ff <= (nxt_power_state != PWR_STOP) || (|rc8_wake_req);
      ext_osc_en_ff <= ext_osc_on && !ext_failed_ff && nxt_power_state != PWR_STOP;
      pll_en_ff <= pll_on && nxt_power_state != PWR_STOP;
      rc48_en_ff <= rc48_on && nxt_power_state != PWR_STOP;
      lowspeed_keep_en_ff <= 1'b1;
    end
  end

  // Readiness of each source, indexed by source code
  assign src_ready = {pin_b_ff[PIN_PLL_LOCK] & pll_en_ff,
                      pin_b_ff[PIN_RC48_RDY] & rc48_en_ff,
                      pin_b_ff[PIN_EXT_RDY] & ext_osc_en_ff,
                      rc8_en_ff};

  // External clock in use, directly or through the loop
  assign ext_in_use = ext_osc_en_ff && (sysclk_src == SRC_EXT ||
                      (sysclk_src == SRC_PLL && pll_src_sel == PLLSRC_EXT));
  assign ext_edge = pin_b_ff[PIN_EXT_TICK] ^ ext_tick_prev_ff;
  assign css_evt = ext_in_use && !ext_edge &&
                   fail_cnt_ff == 8'(FAIL_TIMEOUT_CYC - 1);

  // External clock activity monitor
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_tick_prev_ff <= 1'b0;
      fail_cnt_ff <= '0;
    end else begin
      ext_tick_prev_ff <= pin_b_ff[PIN_EXT_TICK];
      if (!ext_in_use || ext_edge) begin
        fail_cnt_ff <= '0;
      end else if (fail_cnt_ff != 8'(FAIL_TIMEOUT_CYC)) begin
        fail_cnt_ff <= fail_cnt_ff + 8'h01;
      end
    end
  end

  // Failed oscillator stays off until software drops its enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_failed_ff <= 1'b0;
    end else if (css_evt) begin
      ext_failed_ff <= 1'b1;
    end else if (!ext_osc_on) begin
      ext_failed_ff <= 1'b0;
    end
  end

  // RC override after failure or Stop, held until software selects RC
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      force_rc8_ff <= 1'b0;
    end else if (css_evt) begin
      force_rc8_ff <= 1'b1;
    end else if (nxt_power_state == PWR_STOP && power_state_ff != PWR_STOP) begin
      force_rc8_ff <= 1'b1;
    end else if (sw_sysclk_sel == SRC_RC8) begin
      force_rc8_ff <= 1'b0;
    end
  end

  assign req_src = force_rc8_ff ? SRC_RC8 : sw_sysclk_sel;

  // Glitch-free source switch
  clpc_clk_switch #(
    .GAP_CYC(SWITCH_GAP_CYC)
  ) u_switch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req_src(req_src),
    .src_ready(src_ready),
    .gate_en_ff(sysclk_gate),
    .cur_src_ff(sysclk_src),
    .busy_ff(switch_busy)
  );

  // Loop input faults: lock loss or failure of its external input
  assign pll_evt = (pll_was_locked_ff && !pin_b_ff[PIN_PLL_LOCK] && pll_en_ff) ||
                   (css_evt && pll_en_ff && pll_src_sel == PLLSRC_EXT);

  // Sticky fault flags, a new event beats a clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_was_locked_ff <= 1'b0;
      css_flag_ff <= 1'b0;
      pll_flag_ff <= 1'b0;
    end else begin
      pll_was_locked_ff <= pll_en_ff & pin_b_ff[PIN_PLL_LOCK];
      if (css_evt) begin
        css_flag_ff <= 1'b1;
      end else if (css_flag_clr) begin
        css_flag_ff <= 1'b0;
      end
      if (pll_evt) begin
        pll_flag_ff <= 1'b1;
      end else if (pll_flag_clr) begin
        pll_flag_ff <= 1'b0;
      end
    end
  end

  // Interrupt only for enabled flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_irq_ff <= 1'b0;
    end else begin
      clk_irq_ff <= (css_flag_ff & css_irq_en) | (pll_flag_ff & pll_irq_en);
    end
  end

  assign ahb_lim = div_limit(ahb_shift);
  assign apb_lim = div_limit({1'b0, (apb_shift > APB_SHIFT_MAX) ? APB_SHIFT_MAX : apb_shift});

  // Bus prescalers, frozen while core clocks are gated
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ahb_cnt_ff <= '0;
      apb_cnt_ff <= '0;
      ahb_tick_ff <= 1'b0;
      apb_tick_ff <= 1'b0;
    end else if (!core_clk_en_ff) begin
      ahb_tick_ff <= 1'b0;
      apb_tick_ff <= 1'b0;
    end else begin
      ahb_tick_ff <= ahb_cnt_ff >= ahb_lim;
      apb_tick_ff <= (ahb_cnt_ff >= ahb_lim) && (apb_cnt_ff >= apb_lim);
      if (ahb_cnt_ff >= ahb_lim) begin
        ahb_cnt_ff <= '0;
        apb_cnt_ff <= (apb_cnt_ff >= apb_lim) ? 9'h000 : apb_cnt_ff + 9'h001;
      end else begin
        ahb_cnt_ff <= ahb_cnt_ff + 9'h001;
      end
    end
  end

  assign sys_mhz = src_mhz(sysclk_src, pll_src_sel);

  // Flag a bus clock setting above the limit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_overspeed_ff <= 1'b0;
    end else begin
      bus_overspeed_ff <= (sys_mhz >> ahb_shift) > BUS_MAX_MHZ;
    end
  end

  assign sync_rise = pin_b_ff[PIN_SYNC] && !sync_prev_ff;
  assign rc48_edge = pin_b_ff[PIN_RC48_TICK] ^ rc48_tick_prev_ff;

  // Count oscillator ticks per sync period and nudge the trim
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_prev_ff <= 1'b0;
      rc48_tick_prev_ff <= 1'b0;
      trim_cnt_ff <= '0;
      rc48_trim_ff <= TRIM_RESET;
    end else begin
      sync_prev_ff <= pin_b_ff[PIN_SYNC];
      rc48_tick_prev_ff <= pin_b_ff[PIN_RC48_TICK];
      if (!trim_auto_en) begin
        rc48_trim_ff <= trim_sw;
        trim_cnt_ff <= '0;
      end else if (sync_rise) begin
        trim_cnt_ff <= '0;
        // One spare bit so a saturated count cannot wrap the compare
        if ({1'b0, trim_cnt_ff} > {1'b0, SYNC_TARGET} + {1'b0, TRIM_TOL} &&
            rc48_trim_ff != 6'h00) begin
          rc48_trim_ff <= rc48_trim_ff - 6'h01;
        end else if ({1'b0, trim_cnt_ff} + {1'b0, TRIM_TOL} < {1'b0, SYNC_TARGET} &&
                     rc48_trim_ff != TRIM_MAX) begin
          rc48_trim_ff <= rc48_trim_ff + 6'h01;
        end
      end else if (rc48_edge && rc48_en_ff && trim_cnt_ff != 16'hffff) begin
        trim_cnt_ff <= trim_cnt_ff + 16'h0001;
      end
    end
  end

endmodule // clpc_top

// ---- clpc_pkg.sv ----
// Shared constants and types for the clock and low-power controller
package clpc_pkg;

  // System clock sources, one gate bit each
  typedef enum logic [1:0] {
    SRC_RC8  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_RC48 = 2'b10,
    SRC_PLL  = 2'b11
  } clpc_src_t;

  // Power states
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_STOP  = 2'b10
  } clpc_pwr_t;

  // Reference clock rate
  localparam int REF_CLK_MHZ = 125;

  // Dead time between closing one gate and opening the next
  localparam int SWITCH_GAP_NS = 48;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * REF_CLK_MHZ + 999) / 1000;

  // Longest silence of the external clock before it counts as failed
  localparam int FAIL_TIMEOUT_NS = 2000;
  localparam int FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS * REF_CLK_MHZ) / 1000;

  // Source frequencies and bus limit
  localparam int RC8_MHZ = 8;
  localparam int RC48_MHZ = 48;
  localparam int BUS_MAX_MHZ = 48;
  localparam int EXT_MIN_MHZ = 4;
  localparam int EXT_MAX_MHZ = 32;

  // Phase-locked loop input selection
  localparam logic [1:0] PLLSRC_RC8 = 2'h0;
  localparam logic [1:0] PLLSRC_EXT = 2'h1;
  localparam logic [1:0] PLLSRC_RC48 = 2'h2;

  // Prescaler limits
  localparam logic [3:0] AHB_SHIFT_MAX = 4'h9;
  localparam logic [2:0] APB_SHIFT_MAX = 3'h4;

  // Trim code of the 48 MHz oscillator
  localparam logic [5:0] TRIM_RESET = 6'h20;
  localparam logic [5:0] TRIM_MAX = 6'h3f;

  // Bit positions in the synchronised pin vector
  localparam int PIN_W = 38;
  localparam int PIN_EXT_TICK = 0;
  localparam int PIN_EXT_RDY = 1;
  localparam int PIN_RC48_RDY = 2;
  localparam int PIN_PLL_LOCK = 3;
  localparam int PIN_SYNC = 4;
  localparam int PIN_RC48_TICK = 5;
  localparam int PIN_EVT_LSB = 6;

endpackage

// ---- clpc_clk_switch.sv ----
// Glitch-free system clock source switch with break-before-make gating
`timescale 1ns/1ns
module clpc_clk_switch
  import clpc_pkg::*;
#(
  parameter int GAP_CYC = SWITCH_GAP_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire clpc_src_t req_src,
  input wire logic [3:0] src_ready,
  output logic [3:0] gate_en_ff,
  output clpc_src_t cur_src_ff,
  output logic busy_ff
);

  localparam int CW = $clog2(GAP_CYC + 1);

  logic [CW-1:0] gap_cnt_ff;
  clpc_src_t tgt_ff;

  // Close old gate, wait the dead time, open the new one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_en_ff <= 4'h1;
      cur_src_ff <= SRC_RC8;
      tgt_ff <= SRC_RC8;
      busy_ff <= 1'b0;
      gap_cnt_ff <= '0;
    end else if (!busy_ff) begin
      if (req_src != cur_src_ff && src_ready[req_src]) begin
        busy_ff <= 1'b1;
        gate_en_ff <= 4'h0;
        tgt_ff <= req_src;
        gap_cnt_ff <= CW'(GAP_CYC - 1);
      end
    end else if (gap_cnt_ff != '0) begin
      gap_cnt_ff <= gap_cnt_ff - 1'b1;
    end else if (!src_ready[tgt_ff]) begin
      // Target died during the gap: fall back to the RC oscillator
      tgt_ff <= SRC_RC8;
      gap_cnt_ff <= CW'(GAP_CYC - 1);
    end else begin
      gate_en_ff <= 4'(4'h1 << tgt_ff);
      cur_src_ff <= tgt_ff;
      busy_ff <= 1'b0;
    end
  end

endmodule // clpc_clk_switch

// ---- clpc_top_monitor.sv ----
// Port-level checker for the clock and low-power controller
`timescale 1ns/1ns
module clpc_top_monitor
  import clpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic stop_req,
  input wire logic css_irq_en,
  input wire logic pll_irq_en,
  input wire logic io2_below_ref,
  input wire logic [3:0] sysclk_gate,
  input wire clpc_src_t sysclk_src,
  input wire logic css_flag_ff,
  input wire logic clk_irq_ff,
  input wire logic ext_osc_en_ff,
  input wire clpc_pwr_t power_state_ff,
  input wire logic cpu_clk_en_ff,
  input wire logic core_clk_en_ff,
  input wire logic pll_en_ff,
  input wire logic rc48_en_ff,
  input wire logic lowspeed_keep_en_ff,
  input wire logic retain_en_ff,
  input wire logic io2_disable_ff,
  input wire logic event_line31_ff,
  input wire logic wake_pulse_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Clock source gating and switch timing
  gate_match_a: assert property (|sysclk_gate |-> sysclk_gate == (4'h1 << sysclk_src))
    else $error("open gate does not match source");
  switch_gap_a: assert property ($fell(|sysclk_gate) |-> !(|sysclk_gate) [*6])
    else $error("dead time between gates too short");
  switch_done_a: assert property ($fell(|sysclk_gate) |-> ##[6:20] |sysclk_gate)
    else $error("no gate reopened after switch");

  // Low-power modes
  stop_entry_a: assert property (power_state_ff == PWR_RUN && stop_req |=>
    power_state_ff == PWR_STOP && !cpu_clk_en_ff && !core_clk_en_ff)
    else $error("stop request not honoured");
  stop_hold_a: assert property (power_state_ff == PWR_STOP |-> !pll_en_ff && !ext_osc_en_ff
    && !rc48_en_ff && !core_clk_en_ff && retain_en_ff && lowspeed_keep_en_ff)
    else $error("wrong enables in stop");
  sleep_cpu_a: assert property (power_state_ff == PWR_SLEEP |-> !cpu_clk_en_ff && core_clk_en_ff)
    else $error("sleep gates wrong clocks");
  wake_pulse_a: assert property (power_state_ff != PWR_RUN ##1 power_state_ff == PWR_RUN
    |-> wake_pulse_ff)
    else $error("no wake pulse");

  // Clock failure handling
  css_irq_a: assert property ($rose(css_flag_ff) && css_irq_en |=> clk_irq_ff)
    else $error("enabled failure interrupt missing");
  irq_mask_a: assert property (!css_irq_en && !pll_irq_en |=> !clk_irq_ff)
    else $error("interrupt raised while disabled");
  css_fallback_a: assert property ($rose(css_flag_ff) |-> ##[0:1] !ext_osc_en_ff
    ##[0:30] sysclk_src == SRC_RC8)
    else $error("no fallback after failure");

  // Secondary supply monitor
  io2_off_a: assert property (io2_below_ref [*5] |=> io2_disable_ff && event_line31_ff)
    else $error("low supply not acted on");

  // Main scenarios reached
  stop_c: cover property (power_state_ff == PWR_STOP);
  css_c: cover property ($rose(css_flag_ff));
  switch_c: cover property ($fell(|sysclk_gate));
endmodule // clpc_top_monitor

bind clpc_top clpc_top_monitor i_mon (.*);

// ---- clpc_top_tb.sv ----
// Self-checking testbench for the clock and low-power controller
`timescale 1ns/1ns
module clpc_top_tb;
  import clpc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  clpc_src_t sw_sysclk_sel, sysclk_src;
  clpc_pwr_t power_state_ff;
  logic ext_osc_on, rc48_on, pll_on, css_irq_en, pll_irq_en, css_flag_clr, pll_flag_clr;
  logic trim_auto_en, sleep_req, stop_req, irq_pending, ext_clk_tick, ext_ready, tick_run;
  logic rc48_ready, pll_lock, sync_in, rc48_tick, io2_below_ref;
  logic [1:0] pll_src_sel;
  logic [3:0] ahb_shift, rc8_wake_req, sysclk_gate;
  logic [2:0] apb_shift;
  logic [5:0] trim_sw, rc48_trim_ff;
  logic [31:0] event_wake_mask;
  logic [30:0] event_lines;
  logic switch_busy, css_flag_ff, pll_flag_ff, clk_irq_ff, ahb_tick_ff, apb_tick_ff;
  logic bus_overspeed_ff, cpu_clk_en_ff, core_clk_en_ff, rc8_en_ff, ext_osc_en_ff, pll_en_ff;
  logic rc48_en_ff, lowspeed_keep_en_ff, retain_en_ff, io2_disable_ff, event_line31_ff;
  logic wake_pulse_ff;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h1f66;
  int i, a, p, k, n;

  clpc_top i_dut (.*);

  // Clock and external and 48 MHz oscillator tick pins
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (tick_run) {ext_clk_tick, rc48_tick} <= ~{ext_clk_tick, rc48_tick};

  task cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task done(input string nm);
    $display("test %s finished", nm);
  endtask

  // Bounded wait for a finished switch to the given source
  task wsrc(input clpc_src_t s);
    for (int w = 0; w < 60 && !(sysclk_src === s && switch_busy === 1'b0); w++) cyc(1);
    chk("sysclk_src", s, sysclk_src);
  endtask

  // Cycles between two bus ticks, apb when sel is set
  task per(input bit sel, output int c);
    c = 0;
    for (int w = 0; w < 9000 && (sel ? apb_tick_ff : ahb_tick_ff) !== 1'b1; w++) cyc(1);
    do begin
      cyc(1);
      c++;
    end while ((sel ? apb_tick_ff : ahb_tick_ff) !== 1'b1 && c < 9000);
  endtask

  function automatic int divof(input int sh, input int cap);
    return 1 << (sh > cap ? cap : sh);
  endfunction

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    close_out;
  end

  initial begin
    {ext_osc_on, rc48_on, pll_on, css_irq_en, pll_irq_en, css_flag_clr, pll_flag_clr} = '0;
    {trim_auto_en, sleep_req, stop_req, irq_pending, ext_clk_tick, ext_ready, tick_run} = '0;
    {rc48_ready, pll_lock, sync_in, rc48_tick, io2_below_ref} = '0;
    sw_sysclk_sel = SRC_RC8;
    pll_src_sel = PLLSRC_RC48;
    {ahb_shift, apb_shift, rc8_wake_req, event_wake_mask, event_lines} = '0;
    trim_sw = TRIM_RESET;
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk("reset src", SRC_RC8, sysclk_src);
    chk("reset gate", 16'h1, sysclk_gate);
    chk("reset trim", TRIM_RESET, rc48_trim_ff);
    done("reset");
    // Internal 48 MHz source, then refused and accepted loop source
    rc48_on = 1'b1;
    rc48_ready = 1'b1;
    sw_sysclk_sel = SRC_RC48;
    wsrc(SRC_RC48);
    chk("gate rc48", 16'h4, sysclk_gate);
    pll_on = 1'b1;
    pll_irq_en = 1'b1;
    sw_sysclk_sel = SRC_PLL;
    cyc(20);
    chk("unready pll", SRC_RC48, sysclk_src);
    pll_lock = 1'b1;
    wsrc(SRC_PLL);
    cyc(2);
    chk("overspeed", 16'h1, bus_overspeed_ff);
    pll_lock = 1'b0;
    cyc(6);
    chk("pll flag", 16'h1, pll_flag_ff);
    chk("pll irq", 16'h1, clk_irq_ff);
    sw_sysclk_sel = SRC_RC8;
    pll_on = 1'b0;
    pll_flag_clr = 1'b1;
    wsrc(SRC_RC8);
    pll_flag_clr = 1'b0;
    cyc(2);
    chk("pll irq clear", 16'h0, clk_irq_ff);
    done("source select");
    // Bus dividers, capped shifts first
    for (i = 0; i < 5; i++) begin
      a = i ? {$random(seed)} % 4 : 15;
      p = i ? {$random(seed)} % 3 : 7;
      ahb_shift = a[3:0];
      apb_shift = p[2:0];
      cyc(40);
      per(1'b0, n);
      chk("ahb period", divof(a, 9), n);
      per(1'b1, n);
      chk("apb period", divof(a, 9) * divof(p, 4), n);
    end
    chk("no overspeed", 16'h0, bus_overspeed_ff);
    ahb_shift = '0;
    apb_shift = '0;
    done("prescaler");
    // Manual trim, then automatic step saturating at the top
    trim_sw = 6'h3e;
    cyc(4);
    chk("manual trim", 16'h3e, rc48_trim_ff);
    trim_auto_en = 1'b1;
    for (i = 0; i < 2; i++) begin
      sync_in = 1'b1;
      cyc(6);
      sync_in = 1'b0;
      cyc(6);
      chk("auto trim", TRIM_MAX, rc48_trim_ff);
    end
    // Fast oscillator over a long sync period steps the trim down
    tick_run = 1'b1;
    cyc(1600);
    sync_in = 1'b1;
    cyc(6);
    sync_in = 1'b0;
    tick_run = 1'b0;
    chk("trim down", TRIM_MAX - 6'h01, rc48_trim_ff);
    done("trim");
    // Sleep entry and interrupt wake
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    chk("sleep state", PWR_SLEEP, power_state_ff);
    chk("sleep cpu", 16'h0, cpu_clk_en_ff);
    chk("sleep core", 16'h1, core_clk_en_ff);
    irq_pending = 1'b1;
    for (n = 0; n < 10 && power_state_ff !== PWR_RUN; n++) cyc(1);
    chk("sleep wake", PWR_RUN, power_state_ff);
    irq_pending = 1'b0;
    done("sleep");
    // Stop entry and wake by a random line, then by the supply monitor line
    for (i = 0; i < 2; i++) begin
      k = i ? 31 : {$random(seed)} % 31;
      sw_sysclk_sel = SRC_RC48;
      wsrc(SRC_RC48);
      event_wake_mask = 32'h1 << k;
      rc8_wake_req = 4'h1 << ({$random(seed)} % 4);
      stop_req = 1'b1;
      cyc(1);
      stop_req = 1'b0;
      chk("stop state", PWR_STOP, power_state_ff);
      chk("stop rc8 kept", 16'h1, rc8_en_ff);
      chk("stop pll", 16'h0, pll_en_ff);
      chk("stop keep", 16'h1, lowspeed_keep_en_ff);
      chk("stop retain", 16'h1, retain_en_ff);
      rc8_wake_req = '0;
      cyc(1);
      chk("stop rc8 off", 16'h0, rc8_en_ff);
      if (i) io2_below_ref = 1'b1;
      else event_lines = 31'h1 << k;
      for (n = 0; n < 10 && power_state_ff !== PWR_RUN; n++) cyc(1);
      chk("stop wake", PWR_RUN, power_state_ff);
      wsrc(SRC_RC8);
      chk("io2 off", i, io2_disable_ff);
      chk("line31", i, event_line31_ff);
      {event_lines, io2_below_ref} = '0;
      sw_sysclk_sel = SRC_RC8;
      cyc(6);
      chk("io2 back", 16'h0, io2_disable_ff);
    end
    done("stop");
    // External clock use, failure, fallback and interrupt
    ext_osc_on = 1'b1;
    ext_ready = 1'b1;
    tick_run = 1'b1;
    css_irq_en = 1'b1;
    sw_sysclk_sel = SRC_EXT;
    wsrc(SRC_EXT);
    cyc(300);
    chk("no false fail", 16'h0, css_flag_ff);
    tick_run = 1'b0;
    for (n = 0; n < 300 && css_flag_ff !== 1'b1; n++) cyc(1);
    chk("fail flag", 16'h1, css_flag_ff);
    cyc(2);
    chk("fail irq", 16'h1, clk_irq_ff);
    wsrc(SRC_RC8);
    chk("ext off", 16'h0, ext_osc_en_ff);
    css_flag_clr = 1'b1;
    cyc(1);
    css_flag_clr = 1'b0;
    cyc(2);
    chk("flag clear", 16'h0, css_flag_ff);
    chk("irq clear", 16'h0, clk_irq_ff);
    done("clock failure");
    close_out;
  end
endmodule // clpc_top_tb
